// ---- tmu_timer_unit.sv ----
// tmu_timer_unit.sv: timer rate control, timer0 split mode, timer1 and timer2
//
// What this block does
// - timer0 high byte: clock-only counter, timer1 run/flag
// - split mode: timer1 runs in modes 0-2, stops in 3
// - split mode: timer1 still gives baud overflows, readable
// - split mode: timer1 keeps source, rate and gate
// - rate bits 5/4/3: /4 when set, /12 clear
// - rate bits reset to zero
// - rate bits ignored when counting pin edges
// - timer2 baud mode counts every two clocks
// - low three bits set data move length 2+n
// - timer2 is always one 16-bit counter
// - timer2 overflow flag only without serial clock selects
// - software writing 1 to flags raises request
// - enabled trigger capture/reload sets external flag
// - receive clock select: timer2 or timer1 overflows
// - transmit clock select: timer2 or timer1 overflows
// - trigger falling edge acts only when enabled
// - timer2 run bit starts and stops counting
// - timer2 source: divided clock or count pin edges
// - capture on trigger, or reload on overflow/trigger
// - serial clock select forces baud auto-reload mode
// - reload/capture pair holds low and high bytes
// - split mode: low byte uses timer0 controls
// - baud overflow gives shift clock and reloads
`timescale 1ns/1ps
`include "tmu_params.svh"
`default_nettype none

module tmu_timer_unit
  import tmu_pkg::*;
(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // special function register port
  input  wire logic [7:0]   sfr_addr_i,
  input  wire logic         sfr_wr_i,
  input  wire logic         sfr_rd_i,
  input  wire logic [7:0]   sfr_wdata_i,
  output logic      [7:0]   sfr_rdata_o,
  // timer0/1 controls from the core
  input  wire tmu_t01_cfg_t t01_cfg_i,
  // external pins
  input  wire logic         timer0_count_pin_i,
  input  wire logic         timer1_count_pin_i,
  input  wire logic         timer2_count_pin_i,
  input  wire logic         timer2_trigger_pin_i,
  input  wire logic         int0_n_i,
  input  wire logic         int1_n_i,
  // timer0/1 counts and events
  output logic      [7:0]   timer0_low_byte_o,
  output logic      [7:0]   timer0_high_byte_o,
  output logic      [7:0]   timer1_low_byte_o,
  output logic      [7:0]   timer1_high_byte_o,
  output logic              timer0_flag_set_o,
  output logic              timer1_overflow_flag_set_o,
  output logic              timer1_overflow_o,
  // timer2, serial timing and data move length
  output logic              timer2_shift_clk_o,
  output logic              serial_rx_tick_o,
  output logic              serial_tx_tick_o,
  output logic              timer2_irq_o,
  output logic      [3:0]   data_move_cycles_o
);

  tmu_state_t st_r;
  tmu_state_t st_nxt;

  logic [5:0]  agree;
  logic [5:0]  fall;
  logic        tick2;
  logic        split;
  logic        t0_inc;
  logic        t0_ovf;
  logic        th0_inc;
  logic        th0_ovf;
  logic        t1_inc;
  logic        t1_ovf;
  logic [12:0] c13;
  logic        baud;
  logic        t2_inc;
  logic        t2_ovf;
  logic        t2_ext;

  // one tick per rate period of the shared prescaler
  function automatic logic rate_tick(input logic [3:0] p, input logic fast);
    rate_tick = fast ? (p[1:0] == `TMU_DIV4_PHASE) : (p == `TMU_DIV12_PHASE);
  endfunction

  // pin edges bypass the rate selection entirely
  function automatic logic src_tick(input logic src, input logic pin_fall,
                                    input logic clk_tick);
    src_tick = src ? pin_fall : clk_tick;
  endfunction

  // gate hands counting to the interrupt pin level
  function automatic logic gate_ok(input logic run, input logic gate,
                                   input logic int_lvl);
    gate_ok = run & (~gate | int_lvl);
  endfunction

  function automatic logic [3:0] stretch_cycles(input logic [7:0] r);
    stretch_cycles = 4'(`TMU_STRETCH_BASE + {1'b0, r[2:0]});
  endfunction

  always_comb begin
    st_nxt  = st_r;
    agree   = '0;
    fall    = '0;
    tick2   = 1'b0;
    split   = 1'b0;
    t0_inc  = 1'b0;
    t0_ovf  = 1'b0;
    th0_inc = 1'b0;
    th0_ovf = 1'b0;
    t1_inc  = 1'b0;
    t1_ovf  = 1'b0;
    c13     = '0;
    baud    = 1'b0;
    t2_inc  = 1'b0;
    t2_ovf  = 1'b0;
    t2_ext  = 1'b0;

    // three-stage pin sampling; a level counts once stages two and three agree
    st_nxt.sync0 = {int1_n_i, int0_n_i, timer2_trigger_pin_i,
                    timer2_count_pin_i, timer1_count_pin_i, timer0_count_pin_i};
    st_nxt.sync1 = st_r.sync0;
    st_nxt.sync2 = st_r.sync1;
    agree        = ~(st_r.sync1 ^ st_r.sync2);
    st_nxt.lvl   = (st_r.lvl & ~agree) | (st_r.sync2 & agree);
    fall         = st_r.lvl & ~st_nxt.lvl;

    // shared prescaler keeps all timers phase aligned
    if (st_r.pre == `TMU_DIV_LAST) begin
      st_nxt.pre = '0;
    end else begin
      st_nxt.pre = 4'(st_r.pre + 4'h1);
    end
    tick2 = st_r.pre[0];

    // timer0 split: low byte on timer0 controls
    split  = (t01_cfg_i.t0_mode == `TMU_MODE_SPLIT);
    t0_inc = split
           & gate_ok(t01_cfg_i.t0_run, t01_cfg_i.t0_gate, st_r.lvl[TMU_PIN_INT0])
           & src_tick(t01_cfg_i.t0_src, fall[TMU_PIN_T0],
                      rate_tick(st_r.pre, st_r.rate[`TMU_RATE_T0_BIT]));
    t0_ovf = t0_inc & (&st_r.tl0);
    if (t0_inc) begin
      st_nxt.tl0 = 8'(st_r.tl0 + 8'h1);
    end

    // high byte borrows timer1 run; clock source only
    th0_inc = split & t01_cfg_i.t1_run
            & rate_tick(st_r.pre, st_r.rate[`TMU_RATE_T0_BIT]);
    th0_ovf = th0_inc & (&st_r.th0);
    if (th0_inc) begin
      st_nxt.th0 = 8'(st_r.th0 + 8'h1);
    end

    // timer1: in split mode its run bit is lent away, mode 3 stops it
    t1_inc = (t01_cfg_i.t1_mode != `TMU_MODE_SPLIT)
           & gate_ok(split | t01_cfg_i.t1_run, t01_cfg_i.t1_gate,
                     st_r.lvl[TMU_PIN_INT1])
           & src_tick(t01_cfg_i.t1_src, fall[TMU_PIN_T1],
                      rate_tick(st_r.pre, st_r.rate[`TMU_RATE_T1_BIT]));
    if (t1_inc) begin
      case (t01_cfg_i.t1_mode)
        `TMU_MODE_13BIT: begin
          c13          = 13'({st_r.t1cnt[15:8], st_r.t1cnt[4:0]} + 13'h1);
          t1_ovf       = &{st_r.t1cnt[15:8], st_r.t1cnt[4:0]};
          st_nxt.t1cnt = {c13[12:5], st_r.t1cnt[7:5], c13[4:0]};
        end
        `TMU_MODE_16BIT: begin
          t1_ovf       = &st_r.t1cnt;
          st_nxt.t1cnt = 16'(st_r.t1cnt + 16'h1);
        end
        `TMU_MODE_RELOAD8: begin
          t1_ovf = &st_r.t1cnt[7:0];
          if (t1_ovf) begin
            st_nxt.t1cnt[7:0] = st_r.t1cnt[15:8];
          end else begin
            st_nxt.t1cnt[7:0] = 8'(st_r.t1cnt[7:0] + 8'h1);
          end
        end
        default: begin
          t1_ovf = 1'b0;
        end
      endcase
    end

    // timer2 tick source
    baud   = st_r.t2ctl[`TMU_T2_RX_CLK_BIT] | st_r.t2ctl[`TMU_T2_TX_CLK_BIT];
    t2_inc = st_r.t2ctl[`TMU_T2_RUN_BIT]
           & src_tick(st_r.t2ctl[`TMU_T2_SRC_BIT], fall[TMU_PIN_T2],
                      baud ? tick2
                           : rate_tick(st_r.pre, st_r.rate[`TMU_RATE_T2_BIT]));
    t2_ovf = t2_inc & (&st_r.t2cnt);
    t2_ext = fall[TMU_PIN_TIMER2_TRIGGER_PIN] & st_r.t2ctl[`TMU_T2_EXT_EN_BIT];

    // single 16-bit count, wraps to zero unless reloaded
    if (t2_inc) begin
      st_nxt.t2cnt = 16'(st_r.t2cnt + 16'h1);
    end
    if (t2_ovf & (baud | ~st_r.t2ctl[`TMU_T2_CAP_BIT])) begin
      st_nxt.t2cnt = st_r.rcap;
    end
    // trigger edge does nothing to the count while generating baud rates
    if (t2_ext & ~baud) begin
      if (st_r.t2ctl[`TMU_T2_CAP_BIT]) begin
        st_nxt.rcap = st_r.t2cnt;
      end else begin
        st_nxt.t2cnt = st_r.rcap;
      end
    end

    // software writes land even while stopped
    if (sfr_wr_i) begin
      if (sfr_addr_i == `TMU_ADDR_TIMER_RATE) begin
        st_nxt.rate = sfr_wdata_i & `TMU_RATE_USED_MASK;
      end else if (sfr_addr_i == `TMU_ADDR_T2_CTRL) begin
        st_nxt.t2ctl = sfr_wdata_i;
      end else if (sfr_addr_i == `TMU_ADDR_T2_RCAP_LOW) begin
        st_nxt.rcap[7:0] = sfr_wdata_i;
      end else if (sfr_addr_i == `TMU_ADDR_T2_RCAP_HIGH) begin
        st_nxt.rcap[15:8] = sfr_wdata_i;
      end else if (sfr_addr_i == `TMU_ADDR_T2_CNT_LOW) begin
        st_nxt.t2cnt[7:0] = sfr_wdata_i;
      end else if (sfr_addr_i == `TMU_ADDR_T2_CNT_HIGH) begin
        st_nxt.t2cnt[15:8] = sfr_wdata_i;
      end
    end

    // hardware sets win over a same-cycle software clear
    if (t2_ovf & ~baud) begin
      st_nxt.t2ctl[`TMU_T2_OVF_BIT] = 1'b1;
    end
    // in baud mode the edge still raises the flag, without capture or reload
    if (t2_ext) begin
      st_nxt.t2ctl[`TMU_T2_EXT_FLAG_BIT] = 1'b1;
    end

    // registered event and status outputs
    st_nxt.t0_set  = t0_ovf;
    st_nxt.t1_set  = split ? th0_ovf : t1_ovf;
    st_nxt.t1_ovf  = t1_ovf;
    st_nxt.t2_baud = t2_ovf & baud;
    st_nxt.rx_tick = st_r.t2ctl[`TMU_T2_RX_CLK_BIT] ? (t2_ovf & baud) : t1_ovf;
    st_nxt.tx_tick = st_r.t2ctl[`TMU_T2_TX_CLK_BIT] ? (t2_ovf & baud) : t1_ovf;
    st_nxt.irq     = st_nxt.t2ctl[`TMU_T2_OVF_BIT]
                   | st_nxt.t2ctl[`TMU_T2_EXT_FLAG_BIT];
    st_nxt.xcyc    = stretch_cycles(st_nxt.rate);

    // read data one cycle after the strobe; unmapped reads give zero
    st_nxt.rdata = '0;
    if (sfr_rd_i) begin
      if (sfr_addr_i == `TMU_ADDR_TIMER_RATE) begin
        st_nxt.rdata = st_r.rate;
      end else if (sfr_addr_i == `TMU_ADDR_T2_CTRL) begin
        st_nxt.rdata = st_r.t2ctl;
      end else if (sfr_addr_i == `TMU_ADDR_T2_RCAP_LOW) begin
        st_nxt.rdata = st_r.rcap[7:0];
      end else if (sfr_addr_i == `TMU_ADDR_T2_RCAP_HIGH) begin
        st_nxt.rdata = st_r.rcap[15:8];
      end else if (sfr_addr_i == `TMU_ADDR_T2_CNT_LOW) begin
        st_nxt.rdata = st_r.t2cnt[7:0];
      end else if (sfr_addr_i == `TMU_ADDR_T2_CNT_HIGH) begin
        st_nxt.rdata = st_r.t2cnt[15:8];
      end
    end
  end

  // pin levels reset low so no false falling edge follows reset
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_r       <= '0;
      st_r.rate  <= `TMU_RATE_RESET;
      st_r.t2ctl <= `TMU_T2_RESET;
      st_r.xcyc  <= stretch_cycles(`TMU_RATE_RESET);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sfr_rdata_o                = st_r.rdata;
  assign timer0_low_byte_o          = st_r.tl0;
  assign timer0_high_byte_o         = st_r.th0;
  assign timer1_low_byte_o          = st_r.t1cnt[7:0];
  assign timer1_high_byte_o         = st_r.t1cnt[15:8];
  assign timer0_flag_set_o          = st_r.t0_set;
  assign timer1_overflow_flag_set_o = st_r.t1_set;
  assign timer1_overflow_o          = st_r.t1_ovf;
  assign timer2_shift_clk_o         = st_r.t2_baud;
  assign serial_rx_tick_o           = st_r.rx_tick;
  assign serial_tx_tick_o           = st_r.tx_tick;
  assign timer2_irq_o               = st_r.irq;
  assign data_move_cycles_o         = st_r.xcyc;

endmodule

`default_nettype wire

// ---- tmu_params.svh ----
// tmu_params.svh: register offsets, field positions and reset values of the timer unit
`ifndef TMU_PARAMS_SVH
`define TMU_PARAMS_SVH

// special function register addresses
`define TMU_ADDR_TIMER_RATE   8'h8e
`define TMU_ADDR_T2_CTRL      8'hc8
`define TMU_ADDR_T2_RCAP_LOW  8'hca
`define TMU_ADDR_T2_RCAP_HIGH 8'hcb
`define TMU_ADDR_T2_CNT_LOW   8'hcc
`define TMU_ADDR_T2_CNT_HIGH  8'hcd

// reset values
`define TMU_RATE_RESET        8'h01
`define TMU_T2_RESET          8'h00

// timer rate register fields
`define TMU_RATE_T2_BIT       5
`define TMU_RATE_T1_BIT       4
`define TMU_RATE_T0_BIT       3
`define TMU_RATE_USED_MASK    8'h3f
`define TMU_STRETCH_BASE      4'h2

// timer2 control register fields
`define TMU_T2_OVF_BIT        7
`define TMU_T2_EXT_FLAG_BIT   6
`define TMU_T2_RX_CLK_BIT     5
`define TMU_T2_TX_CLK_BIT     4
`define TMU_T2_EXT_EN_BIT     3
`define TMU_T2_RUN_BIT        2
`define TMU_T2_SRC_BIT        1
`define TMU_T2_CAP_BIT        0

// prescaler: mod-12 counter gives the /2, /4 and /12 ticks
`define TMU_DIV_LAST          4'hb
`define TMU_DIV4_PHASE        2'h3
`define TMU_DIV12_PHASE       4'hb

// timer0/1 mode encodings
`define TMU_MODE_13BIT        2'h0
`define TMU_MODE_16BIT        2'h1
`define TMU_MODE_RELOAD8      2'h2
`define TMU_MODE_SPLIT        2'h3

`endif

// ---- tmu_pkg.sv ----
// tmu_pkg.sv: types shared by the timer unit
`default_nettype none
package tmu_pkg;

  // pin indices of the synchroniser vector
  typedef enum logic [2:0] {
    TMU_PIN_T0   = 3'h0,
    TMU_PIN_T1   = 3'h1,
    TMU_PIN_T2   = 3'h2,
    TMU_PIN_TIMER2_TRIGGER_PIN = 3'h3,
    TMU_PIN_INT0 = 3'h4,
    TMU_PIN_INT1 = 3'h5
  } tmu_pin_t;

  // timer0/1 controls held by registers outside this unit
  typedef struct packed {
    logic [1:0] t0_mode;
    logic       t0_run;
    logic       t0_src;
    logic       t0_gate;
    logic [1:0] t1_mode;
    logic       t1_run;
    logic       t1_src;
    logic       t1_gate;
  } tmu_t01_cfg_t;

  typedef struct packed {
    logic [3:0]  pre;
    logic [5:0]  sync0;
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic [5:0]  lvl;
    logic [7:0]  rate;
    logic [7:0]  t2ctl;
    logic [15:0] rcap;
    logic [15:0] t2cnt;
    logic [7:0]  tl0;
    logic [7:0]  th0;
    logic [15:0] t1cnt;
    logic [7:0]  rdata;
    logic        t0_set;
    logic        t1_set;
    logic        t1_ovf;
    logic        t2_baud;
    logic        rx_tick;
    logic        tx_tick;
    logic        irq;
    logic [3:0]  xcyc;
  } tmu_state_t;

endpackage
`default_nettype wire

// ---- tmu_cpu_model.sv ----
// tmu_cpu_model.sv: cpu core stand-in that issues special function register accesses
`timescale 1ns/1ps
`include "tmu_params.svh"
`default_nettype none
module tmu_cpu_model (
  // clock
  input  wire logic       clk_i,
  // register port towards the timer unit
  output logic      [7:0] sfr_addr_o,
  output logic            sfr_wr_o,
  output logic            sfr_rd_o,
  output logic      [7:0] sfr_wdata_o,
  input  wire logic [7:0] sfr_rdata_i
);
  initial begin
    sfr_addr_o = 8'h00;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    sfr_wdata_o = 8'h00;
  end
  // called at a falling edge; an idle cycle follows so strobes never toggle twice at one time
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_o = a;
    sfr_wdata_o = d;
    sfr_wr_o = 1'b1;
    @(negedge clk_i);
    sfr_wr_o = 1'b0;
    sfr_wdata_o = ~d;
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr_o = a;
    sfr_rd_o = 1'b1;
    @(negedge clk_i);
    d = sfr_rdata_i;
    sfr_rd_o = 1'b0;
    @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- tmu_timer_monitor.sv ----
// tmu_timer_monitor.sv: port-level assertions for the timer unit
`timescale 1ns/1ps
`include "tmu_params.svh"
`default_nettype none
module tmu_timer_monitor (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [7:0] timer0_low_byte_o,
  input wire logic [7:0] timer0_high_byte_o,
  input wire logic       timer1_overflow_o,
  input wire logic       timer2_shift_clk_o,
  input wire logic       serial_rx_tick_o,
  input wire logic       serial_tx_tick_o,
  input wire logic       timer2_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic ctl_wr;
  assign ctl_wr = sfr_wr_i && (sfr_addr_i == `TMU_ADDR_T2_CTRL);
  chk_rate_resv: assert property (sfr_rd_i && sfr_addr_i == `TMU_ADDR_TIMER_RATE
    |=> sfr_rdata_o[7:6] == 2'h0) else $error("reserved rate bits read nonzero");
  chk_rdata_idle: assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00)
    else $error("read data not idle");
  chk_tx_source: assert property (serial_tx_tick_o |-> timer2_shift_clk_o || timer1_overflow_o)
    else $error("transmit tick without overflow");
  chk_rx_source: assert property (serial_rx_tick_o |-> timer2_shift_clk_o || timer1_overflow_o)
    else $error("receive tick without overflow");
  chk_shift_gap: assert property (timer2_shift_clk_o |=> !timer2_shift_clk_o)
    else $error("shift clock faster than two clocks");
  chk_irq_hold: assert property ($fell(timer2_irq_o) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("timer2 request dropped without software clear");
  chk_t1_pulse: assert property (timer1_overflow_o |=> !timer1_overflow_o)
    else $error("timer1 overflow pulse too long");
  chk_low_step: assert property ($changed(timer0_low_byte_o)
    |-> timer0_low_byte_o == $past(timer0_low_byte_o) + 8'h01) else $error("low byte jumped");
  chk_low_gap: assert property ($changed(timer0_low_byte_o) |=> $stable(timer0_low_byte_o)[*3])
    else $error("low byte counts faster than four clocks");
  chk_high_step: assert property ($changed(timer0_high_byte_o)
    |-> timer0_high_byte_o == $past(timer0_high_byte_o) + 8'h01) else $error("high byte jumped");
endmodule
bind tmu_timer_unit tmu_timer_monitor mon (.clk_i(clk_i), .resetn_i(resetn_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
  .timer0_low_byte_o(timer0_low_byte_o), .timer0_high_byte_o(timer0_high_byte_o),
  .timer1_overflow_o(timer1_overflow_o), .timer2_shift_clk_o(timer2_shift_clk_o),
  .serial_rx_tick_o(serial_rx_tick_o), .serial_tx_tick_o(serial_tx_tick_o),
  .timer2_irq_o(timer2_irq_o));
`default_nettype wire

// ---- tmu_timer_unit_test.sv ----
// tmu_timer_unit_test.sv: self-checking bench for the timer unit
`timescale 1ns/1ps
`include "tmu_params.svh"
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tmu_timer_unit_test;
  import tmu_pkg::*;
  logic         clk_i, resetn_i, sfr_wr, sfr_rd, t2_pin, timer2_trigger_pin_pin;
  logic [7:0]   sfr_addr, sfr_wdata, sfr_rdata, tl0, th0, tl1, th1;
  logic         t0f, t1fs, t1ov, sclk, rxt, txt, irq;
  logic [3:0]   mcyc;
  tmu_t01_cfg_t cfg;
  int           fails = 0, n_tests = 0, cycles = 0;
  tmu_cpu_model cpu (.clk_i(clk_i), .sfr_addr_o(sfr_addr), .sfr_wr_o(sfr_wr), .sfr_rd_o(sfr_rd),
    .sfr_wdata_o(sfr_wdata), .sfr_rdata_i(sfr_rdata));
  tmu_timer_unit uut (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr), .sfr_wr_i(sfr_wr),
    .sfr_rd_i(sfr_rd), .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata), .t01_cfg_i(cfg),
    .timer0_count_pin_i(1'b1), .timer1_count_pin_i(1'b1), .timer2_count_pin_i(t2_pin),
    .timer2_trigger_pin_i(timer2_trigger_pin_pin), .int0_n_i(1'b1), .int1_n_i(1'b1),
    .timer0_low_byte_o(tl0), .timer0_high_byte_o(th0), .timer1_low_byte_o(tl1),
    .timer1_high_byte_o(th1), .timer0_flag_set_o(t0f), .timer1_overflow_flag_set_o(t1fs),
    .timer1_overflow_o(t1ov), .timer2_shift_clk_o(sclk), .serial_rx_tick_o(rxt),
    .serial_tx_tick_o(txt), .timer2_irq_o(irq), .data_move_cycles_o(mcyc));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // count gain of a register over exactly 48 clocks, a multiple of every divider
  task automatic span(input logic [7:0] a, output logic [7:0] n);
    logic [7:0] d0, d1;
    cpu.rd(a, d0);
    repeat (46) @(negedge clk_i);
    cpu.rd(a, d1);
    n = d1 - d0;
  endtask
  task automatic fall(ref logic pin);
    pin = 1'b0;
    repeat (6) @(negedge clk_i);
    pin = 1'b1;
    repeat (6) @(negedge clk_i);
  endtask
  task automatic t_reset();
    logic [7:0] d;
    `CHK(mcyc, 4'h3)
    cpu.rd(`TMU_ADDR_TIMER_RATE, d);
    `CHK(d, 8'h01)
    cpu.rd(8'h8f, d);
    `CHK(d, 8'h00)
    cpu.wr(`TMU_ADDR_TIMER_RATE, 8'hff);
    cpu.rd(`TMU_ADDR_TIMER_RATE, d);
    `CHK(d, 8'h3f)
    `CHK(mcyc, 4'h9)
  endtask
  task automatic t_rates();
    logic [7:0] n;
    cpu.wr(`TMU_ADDR_T2_CTRL, 8'h04);
    span(`TMU_ADDR_T2_CNT_LOW, n);
    `CHK(n, 8'h0c)
    cpu.wr(`TMU_ADDR_TIMER_RATE, 8'h00);
    span(`TMU_ADDR_T2_CNT_LOW, n);
    `CHK(n, 8'h04)
    cpu.wr(`TMU_ADDR_T2_CTRL, 8'h00);
    span(`TMU_ADDR_T2_CNT_LOW, n);
    `CHK(n, 8'h00)
    cpu.wr(`TMU_ADDR_T2_CNT_LOW, 8'h5a);
    cpu.rd(`TMU_ADDR_T2_CNT_LOW, n);
    `CHK(n, 8'h5a)
  endtask
  task automatic t_baud();
    logic [7:0] n;
    int p, r, t;
    cpu.wr(`TMU_ADDR_T2_CTRL, 8'h34);
    span(`TMU_ADDR_T2_CNT_LOW, n);
    `CHK(n, 8'h18)
    cpu.wr(`TMU_ADDR_T2_RCAP_LOW, 8'hfe);
    cpu.wr(`TMU_ADDR_T2_RCAP_HIGH, 8'hff);
    cpu.wr(`TMU_ADDR_T2_CNT_LOW, 8'hfe);
    cpu.wr(`TMU_ADDR_T2_CNT_HIGH, 8'hff);
    repeat (8) @(negedge clk_i);
    p = 0;
    r = 0;
    t = 0;
    repeat (48) begin
      @(negedge clk_i);
      p += sclk;
      r += rxt;
      t += txt;
    end
    `CHK(p, 12)
    `CHK(r, 12)
    `CHK(t, 12)
    `CHK(irq, 1'b0)
    cpu.wr(`TMU_ADDR_T2_CTRL, 8'h00);
  endtask
  task automatic t_reload();
    logic [7:0] d;
    cpu.wr(`TMU_ADDR_T2_CNT_LOW, 8'hff);
    cpu.wr(`TMU_ADDR_T2_RCAP_LOW, 8'h34);
    cpu.wr(`TMU_ADDR_T2_RCAP_HIGH, 8'h12);
    cpu.wr(`TMU_ADDR_T2_CTRL, 8'h04);
    for (int i = 0; i < 20 && irq !== 1'b1; i++) @(negedge clk_i);
    `CHK(irq, 1'b1)
    cpu.rd(`TMU_ADDR_T2_CTRL, d);
    `CHK(d, 8'h84)
    cpu.rd(`TMU_ADDR_T2_CNT_HIGH, d);
    `CHK(d, 8'h12)
    cpu.wr(`TMU_ADDR_T2_CTRL, 8'h00);
    `CHK(irq, 1'b0)
    cpu.wr(`TMU_ADDR_T2_CTRL, 8'h80);
    `CHK(irq, 1'b1)
    cpu.wr(`TMU_ADDR_T2_CTRL, 8'h40);
    `CHK(irq, 1'b1)
    cpu.wr(`TMU_ADDR_T2_CTRL, 8'h00);
  endtask
  task automatic t_capture();
    logic [7:0] d;
    cpu.wr(`TMU_ADDR_TIMER_RATE, 8'h20);
    cpu.wr(`TMU_ADDR_T2_CNT_LOW, 8'h77);
    cpu.wr(`TMU_ADDR_T2_CNT_HIGH, 8'h66);
    cpu.wr(`TMU_ADDR_T2_CTRL, 8'h07);
    fall(timer2_trigger_pin_pin);
    cpu.rd(`TMU_ADDR_T2_CTRL, d);
    `CHK(d, 8'h07)
    cpu.rd(`TMU_ADDR_T2_CNT_LOW, d);
    `CHK(d, 8'h77)
    repeat (3) fall(t2_pin);
    cpu.wr(`TMU_ADDR_T2_CTRL, 8'h0f);
    fall(timer2_trigger_pin_pin);
    cpu.rd(`TMU_ADDR_T2_RCAP_LOW, d);
    `CHK(d, 8'h7a)
    cpu.rd(`TMU_ADDR_T2_RCAP_HIGH, d);
    `CHK(d, 8'h66)
    cpu.rd(`TMU_ADDR_T2_CTRL, d);
    `CHK(d, 8'h4f)
    cpu.wr(`TMU_ADDR_T2_CNT_LOW, 8'h00);
    cpu.wr(`TMU_ADDR_T2_CTRL, 8'h0e);
    fall(timer2_trigger_pin_pin);
    cpu.rd(`TMU_ADDR_T2_CNT_LOW, d);
    `CHK(d, 8'h7a)
    cpu.wr(`TMU_ADDR_T2_CTRL, 8'h00);
  endtask
  // split mode gains of timer0 low, timer0 high and timer1 low over 48 clocks at rate /4
  task automatic split_span(input logic [9:0] c, input logic [7:0] e0, e1, e2);
    logic [7:0] a, b, d;
    cfg = c;
    repeat (2) @(negedge clk_i);
    a = tl0;
    b = th0;
    d = tl1;
    repeat (48) @(negedge clk_i);
    `CHK(tl0 - a, e0)
    `CHK(th0 - b, e1)
    `CHK(tl1 - d, e2)
  endtask
  task automatic t_split();
    int f0, f1, ov;
    cpu.wr(`TMU_ADDR_TIMER_RATE, 8'h18);
    // fields: t0 mode 3 run, t1 mode 2 run, clock source, no gate
    split_span(10'h394, 8'h0c, 8'h0c, 8'h0c);
    split_span(10'h390, 8'h0c, 8'h00, 8'h0c);
    split_span(10'h39c, 8'h0c, 8'h0c, 8'h00);
    cfg = 10'h394;
    f0 = 0;
    f1 = 0;
    ov = 0;
    repeat (1024) begin
      @(negedge clk_i);
      f0 += t0f;
      f1 += t1fs;
      ov += t1ov;
    end
    `CHK(f0, 1)
    `CHK(f1, 1)
    `CHK(ov, 1)
    `CHK(th1, 8'h00)
  endtask
  initial begin
    resetn_i = 1'b0;
    cfg = '0;
    t2_pin = 1'b1;
    timer2_trigger_pin_pin = 1'b1;
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    @(negedge clk_i);
    t_reset();
    t_rates();
    t_baud();
    t_reload();
    t_capture();
    t_split();
    wrap_up();
  end
endmodule
`default_nettype wire
